// ===== rtl/bmc_pkg.sv
// Constants, register map and types of the burst modulation controller
package bmc_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int          CLK_HZ       = 200_000_000;
	localparam int          CAR_MUL      = 9;          // Carrier step multiplier
	localparam int          PH_FULL_MDEG = 360_000;    // One turn in millidegrees
	// Carrier accumulator modulus: clock rate in centihertz times CAR_MUL
	localparam logic [37:0] CAR_MOD      = 38'(64'(CLK_HZ) * 64'd100 * 64'(CAR_MUL));
	localparam logic [37:0] PH_SCALE     = 38'(CAR_MOD / 38'(PH_FULL_MDEG));
	// Rate accumulator modulus: clock rate in millihertz
	localparam logic [37:0] RATE_MOD     = 38'(64'(CLK_HZ) * 64'd1000);

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] A_CTRL    = 8'h00;
	localparam logic [7:0] A_COUNT   = 8'h04;
	localparam logic [7:0] A_PHASE   = 8'h08;
	localparam logic [7:0] A_RATE    = 8'h0C;
	localparam logic [7:0] A_FREQ    = 8'h10;
	localparam logic [7:0] A_TRIG    = 8'h14;
	localparam logic [7:0] A_STATUS  = 8'h18;
	localparam logic [7:0] A_IRQ_EN  = 8'h1C;
	localparam logic [7:0] A_IRQ_CLR = 8'h20;
	localparam logic [7:0] A_ERR     = 8'h24;
	localparam logic [7:0] A_STATE   = 8'h28;

	// ----------------------------------------------------------------
	// Field values, limits and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0]  MOD_OFF   = 3'h0;
	localparam logic [2:0]  MOD_AM    = 3'h1;
	localparam logic [2:0]  MOD_FM    = 3'h2;
	localparam logic [2:0]  MOD_FSK   = 3'h3;
	localparam logic [2:0]  MOD_SWEEP = 3'h4;
	localparam logic [2:0]  MOD_BURST = 3'h5;
	localparam logic [2:0]  SHP_SINE  = 3'h0;
	localparam logic [2:0]  SHP_SQU   = 3'h1;
	localparam logic [2:0]  SHP_TRI   = 3'h2;
	localparam logic [2:0]  SHP_RAMP  = 3'h3;
	localparam logic [2:0]  SHP_USER  = 3'h4;
	localparam logic [1:0]  TRG_INT   = 2'h0;
	localparam logic [1:0]  TRG_EXT   = 2'h1;
	localparam logic [1:0]  TRG_BPL   = 2'h2;
	localparam logic [1:0]  TRG_SOFT  = 2'h3;
	localparam logic [15:0] CNT_MIN   = 16'h0001;
	localparam logic [15:0] CNT_MAX   = 16'hC350;      // 50000 cycles
	localparam logic [15:0] CNT_DEF   = 16'h0001;
	localparam int          CNT_INF_BIT = 31;
	localparam logic [31:0] CNT_INF_READ = 32'h7E94F575; // +9.9E+37 as float
	localparam logic [31:0] PH_MAX    = 32'h00057E40;  // +360000 mdeg
	localparam logic [31:0] PH_MIN    = 32'hFFFA81C0;  // -360000 mdeg
	localparam logic [19:0] PH_DEF    = 20'h00000;
	localparam logic [31:0] RATE_MIN  = 32'h0000000A;  // 10 mHz
	localparam logic [31:0] RATE_MAX  = 32'h02FAF080;  // 50 kHz in mHz
	localparam logic [25:0] RATE_DEF  = 26'h00186A0;   // 100 Hz in mHz
	localparam logic [28:0] F_MIN     = 29'h00000001;  // 10 mHz in cHz
	localparam logic [28:0] F_MAX     = 29'h1DCD6500;  // 5 MHz in cHz
	localparam logic [28:0] F_TRI_MAX = 29'h00989680;  // 100 kHz in cHz
	localparam logic [28:0] F_DEF     = 29'h000186A0;  // 1 kHz in cHz
	localparam logic [28:0] F_STEP    = 29'h05F5E100;  // 1 MHz in cHz
	localparam logic [28:0] F_LOW     = 29'h00002710;  // 100 Hz in cHz
	localparam logic [15:0] DUR_DIV   = 16'h0005;      // 500 s span in cHz units
	localparam logic [15:0] CNT_STEP_LIM = 16'h0005;   // Counts below this limit
	localparam logic [31:0] ERR_CONFLICT = 32'hFFFFFF23; // -221
	localparam int          ST_CONFLICT = 0;
	localparam int          ST_DONE     = 1;
	localparam int          ST_BITS     = 2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] shape;
		logic [1:0] trig_src;
		logic       src_ext;
		logic [2:0] mod_mode;
	} bmc_ctrl_type;

	localparam bmc_ctrl_type CTRL_DEF = '{shape: SHP_SINE, trig_src: TRG_INT,
		src_ext: 1'b0, mod_mode: MOD_OFF};

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN  = 3'b010,
		ST_GATE = 3'b100
	} bmc_state_type;

endpackage

// ===== rtl/bmc_burst_ctrl.sv
// Burst modulation controller: APB registers, counted and gated bursts
// Contract
// - Cycle count 1 to 50000 or infinite, default 1, counted mode only.
// - Count readback gives 1 to 50000, or +9.9E37 code when infinite.
// - Sine, square, arb need count of one per started MHz of carrier.
// - Carrier too fast for count is clamped to the highest legal value, error -221.
// - At 100 Hz or less, count over carrier stays within 500 s, else raise.
// - Start phase -360 to +360 degrees in millidegrees, default 0, counted mode.
// - Zero phase is rising offset crossing, or first stored sample for arb.
// - Internal burst rate 10 mHz to 50 kHz, default 100 Hz, sets burst spacing.
// - Internal rate used only with internal triggering.
// - Too fast a rate makes bursts retrigger back to back; readback unchanged.
// - Gated mode gives carrier while gate high, offset level while low.
// - Gate comes from front trigger pin or backplane line per trigger source.
// - Gated mode ignores count, rate and phase; trigger source only picks the gate pin. Code still applies the count's carrier limit in gated mode.
// - Internal burst source, the default, selects counted bursts.
// - One modulation active; enabling burst turns off the previous one.
// - Burst carrier 10 mHz to 5 MHz, 100 kHz for triangle and ramp, default 1 kHz.
`timescale 1ns/1ps
module bmc_burst_ctrl (
	// Clock and reset
	input  wire logic                 CLK,
	input  wire logic                 RST,
	// APB slave
	input  wire logic                 PSEL,
	input  wire logic                 PENABLE,
	input  wire logic                 PWRITE,
	input  wire logic [7:0]           PADDR,
	input  wire logic [31:0]          PWDATA,
	output logic      [31:0]          PRDATA,
	output logic                      PREADY,
	output logic                      PSLVERR,
	// Trigger and gate pins
	input  wire logic                 EXT_TRIG,
	input  wire logic                 BACKPLANE_TRIG,
	// Carrier control
	output logic                      CARRIER_ON,
	output logic      [37:0]          CARRIER_PHASE,
	output logic                      BURST_ACTIVE,
	output bmc_pkg::bmc_ctrl_type     CTRL_OUT,
	// Interrupt
	output logic                      IRQ
);
	import bmc_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	bmc_ctrl_type       ctrl_q;
	logic [15:0]        count_q;
	logic               inf_q;
	logic signed [19:0] phase_q;
	logic [25:0]        rate_q;
	logic [28:0]        freq_q;
	logic [ST_BITS-1:0] status_q;
	logic [ST_BITS-1:0] irq_en_q;
	logic               recheck_q;
	logic               soft_trig_q;
	logic [1:0]         ext_sync_q;
	logic [1:0]         bpl_sync_q;
	logic               ext_prev_q;
	logic               bpl_prev_q;
	logic [37:0]        rate_acc_q;
	logic               pend_q;
	bmc_state_type      state_q;
	logic [37:0]        rel_q;
	logic [15:0]        left_q;
	logic               done_q;
	logic               conflict_q;
	logic [28:0]        fixed_f;
	logic               wr;
	logic               rd_setup;
	logic               burst_en;
	logic               counted;
	logic               gated;
	logic               gate_lvl;
	logic               trig_evt;
	logic               rate_tick;
	logic [37:0]        rate_sum;
	logic [37:0]        rel_sum;
	logic               wrap;
	logic               start;
	logic [37:0]        ph_off;
	logic [37:0]        abs_ph;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Legal carrier for the present count and shape
	function automatic logic [28:0] fix_carrier(input logic [28:0] f,
		input logic [15:0] n, input logic inf, input logic [2:0] shp);
		logic [28:0] r;
		logic [28:0] lim;
		logic [15:0] lo;
		logic        slow;
		r    = f;
		slow = (shp == SHP_TRI) || (shp == SHP_RAMP);
		lim  = 29'(n[2:0]) * F_STEP;
		lo   = (n + DUR_DIV - CNT_MIN) / DUR_DIV;
		if (r < F_MIN) begin
			r = F_MIN;
		end
		if (r > F_MAX) begin
			r = F_MAX;
		end
		if (slow && r > F_TRI_MAX) begin
			r = F_TRI_MAX;
		end
		if (!slow && !inf && n < CNT_STEP_LIM && r > lim) begin
			r = lim;
		end
		if (!inf && r <= F_LOW && r < 29'(lo)) begin
			r = 29'(lo);
		end
		return r;
	endfunction

	// Clamp a signed word into a range
	function automatic logic [31:0] clamp_s(input logic [31:0] v,
		input logic [31:0] lo, input logic [31:0] hi);
		logic [31:0] r;
		r = v;
		if ($signed(v) < $signed(lo)) begin
			r = lo;
		end
		if ($signed(v) > $signed(hi)) begin
			r = hi;
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Bus decode and mode terms
	// ----------------------------------------------------------------
	// Zero wait state slave
	assign PREADY   = 1'b1;
	assign wr       = PSEL && PENABLE && PWRITE;
	assign rd_setup = PSEL && !PENABLE && !PWRITE;
	assign burst_en = (ctrl_q.mod_mode == MOD_BURST);
	assign counted  = burst_en && !ctrl_q.src_ext;
	assign gated    = burst_en && ctrl_q.src_ext;
	assign gate_lvl = (ctrl_q.trig_src == TRG_BPL) ? bpl_sync_q[1] : ext_sync_q[1];
	assign fixed_f  = fix_carrier(freq_q, count_q, inf_q, ctrl_q.shape);
	assign CTRL_OUT = ctrl_q;

	// ----------------------------------------------------------------
	// Registers written by software
	// ----------------------------------------------------------------
	// Control: one encoded mode field keeps a single modulation active
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctrl_q <= CTRL_DEF;
		end else if (wr && PADDR == A_CTRL) begin
			ctrl_q <= bmc_ctrl_type'(PWDATA[$bits(bmc_ctrl_type)-1:0]);
		end
	end

	// Cycle count with infinite flag
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			count_q <= CNT_DEF;
			inf_q   <= 1'b0;
		end else if (wr && PADDR == A_COUNT) begin
			inf_q <= PWDATA[CNT_INF_BIT];
			if (PWDATA[30:0] < 31'(CNT_MIN)) begin
				count_q <= CNT_MIN;
			end else if (PWDATA[30:0] > 31'(CNT_MAX)) begin
				count_q <= CNT_MAX;
			end else begin
				count_q <= PWDATA[15:0];
			end
		end
	end

	// Start phase in millidegrees
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			phase_q <= PH_DEF;
		end else if (wr && PADDR == A_PHASE) begin
			phase_q <= 20'(clamp_s(PWDATA, PH_MIN, PH_MAX));
		end
	end

	// Internal burst rate in millihertz, clamped to 10 mHz to 50 kHz
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rate_q <= RATE_DEF;
		end else if (wr && PADDR == A_RATE) begin
			rate_q <= 26'(clamp_s(PWDATA, RATE_MIN, RATE_MAX));
		end
	end

	// Carrier frequency, corrected one cycle after a relevant write
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			freq_q <= F_DEF;
		end else if (wr && PADDR == A_FREQ) begin
			freq_q <= (PWDATA > 32'(F_MAX)) ? F_MAX : PWDATA[28:0];
		end else if (recheck_q && burst_en) begin
			freq_q <= fixed_f;
		end
	end

	// Recheck request and conflict event
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			recheck_q  <= 1'b0;
			conflict_q <= 1'b0;
		end else begin
			recheck_q  <= wr && (PADDR == A_CTRL || PADDR == A_COUNT || PADDR == A_FREQ);
			conflict_q <= recheck_q && burst_en && (fixed_f != freq_q);
		end
	end

	// Software trigger pulse
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			soft_trig_q <= 1'b0;
		end else begin
			soft_trig_q <= wr && PADDR == A_TRIG;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status, enable and clear
	// ----------------------------------------------------------------
	// Sticky status: a new event wins over a clear in the same cycle
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			status_q <= '0;
		end else begin
			status_q <= (status_q & ~((wr && PADDR == A_IRQ_CLR) ?
				PWDATA[ST_BITS-1:0] : '0)) | {done_q, conflict_q};
		end
	end

	// Enable mask
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			irq_en_q <= '0;
		end else if (wr && PADDR == A_IRQ_EN) begin
			irq_en_q <= PWDATA[ST_BITS-1:0];
		end
	end

	assign IRQ = |(status_q & irq_en_q);

	// ----------------------------------------------------------------
	// Read data and error answer
	// ----------------------------------------------------------------
	// Read data captured in the setup cycle
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			PRDATA <= '0;
		end else if (rd_setup) begin
			case (PADDR)
				A_CTRL: begin
					PRDATA <= 32'(ctrl_q);
				end
				A_COUNT: begin
					PRDATA <= inf_q ? CNT_INF_READ : 32'(count_q);
				end
				A_PHASE: begin
					PRDATA <= 32'(signed'(phase_q));
				end
				A_RATE: begin
					PRDATA <= 32'(rate_q);
				end
				A_FREQ: begin
					PRDATA <= 32'(freq_q);
				end
				A_STATUS: begin
					PRDATA <= 32'(status_q);
				end
				A_IRQ_EN: begin
					PRDATA <= 32'(irq_en_q);
				end
				A_ERR: begin
					PRDATA <= status_q[ST_CONFLICT] ? ERR_CONFLICT : '0;
				end
				A_STATE: begin
					PRDATA <= {8'h00, 1'b0, pend_q, CARRIER_ON, 2'b00, state_q, left_q};
				end
				default: begin
					PRDATA <= '0;
				end
			endcase
		end
	end

	// Error for unmapped addresses, reads of write-only words and writes of read-only words
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			PSLVERR <= 1'b0;
		end else if (PSEL && !PENABLE) begin
			PSLVERR <= (PADDR > A_STATE) || (PADDR[1:0] != 2'b00) ||
				(!PWRITE && (PADDR == A_TRIG || PADDR == A_IRQ_CLR)) ||
				(PWRITE && (PADDR == A_STATUS || PADDR == A_ERR || PADDR == A_STATE));
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers and trigger sources
	// ----------------------------------------------------------------
	// Two flops per pin, edge taken after the second
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ext_sync_q <= '0;
			bpl_sync_q <= '0;
			ext_prev_q <= 1'b0;
			bpl_prev_q <= 1'b0;
		end else begin
			ext_sync_q <= {ext_sync_q[0], EXT_TRIG};
			bpl_sync_q <= {bpl_sync_q[0], BACKPLANE_TRIG};
			ext_prev_q <= ext_sync_q[1];
			bpl_prev_q <= bpl_sync_q[1];
		end
	end

	// Internal rate accumulator, runs only with internal triggering
	assign rate_sum  = rate_acc_q + 38'(rate_q);
	assign rate_tick = (rate_sum >= RATE_MOD);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rate_acc_q <= '0;
		end else if (!counted || ctrl_q.trig_src != TRG_INT) begin
			rate_acc_q <= '0;
		end else begin
			rate_acc_q <= rate_tick ? rate_sum - RATE_MOD : rate_sum;
		end
	end

	// Trigger event for the selected source
	always_comb begin
		case (ctrl_q.trig_src)
			TRG_INT: begin
				trig_evt = rate_tick;
			end
			TRG_EXT: begin
				trig_evt = ext_sync_q[1] && !ext_prev_q;
			end
			TRG_BPL: begin
				trig_evt = bpl_sync_q[1] && !bpl_prev_q;
			end
			default: begin
				trig_evt = soft_trig_q;
			end
		endcase
	end

	// Pending trigger, held while a burst runs so the next follows at once
	assign start = counted && (state_q == ST_IDLE) && pend_q;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pend_q <= 1'b0;
		end else if (!counted) begin
			pend_q <= 1'b0;
		end else begin
			pend_q <= trig_evt || (pend_q && !start);
		end
	end

	// ----------------------------------------------------------------
	// Burst sequencer
	// ----------------------------------------------------------------
	assign rel_sum = rel_q + 38'(freq_q) * 38'(CAR_MUL);
	assign wrap    = (rel_sum >= CAR_MOD);

	// Mode, cycle count and relative carrier phase
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_q <= ST_IDLE;
			rel_q   <= '0;
			left_q  <= '0;
			done_q  <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (gated) begin
						state_q <= ST_GATE;
						rel_q   <= '0;
					end else if (start) begin
						state_q <= ST_RUN;
						rel_q   <= '0;
						left_q  <= count_q;
					end else if (!burst_en) begin
						rel_q <= wrap ? rel_sum - CAR_MOD : rel_sum;
					end else begin
						rel_q <= '0;
					end
				end
				ST_RUN: begin
					if (!counted) begin
						state_q <= ST_IDLE;
						rel_q   <= '0;
					end else if (wrap && !inf_q && left_q == CNT_MIN) begin
						state_q <= ST_IDLE;
						rel_q   <= '0;
						done_q  <= 1'b1;
					end else begin
						rel_q <= wrap ? rel_sum - CAR_MOD : rel_sum;
						if (wrap && !inf_q) begin
							left_q <= left_q - CNT_MIN;
						end
					end
				end
				ST_GATE: begin
					if (!gated) begin
						state_q <= ST_IDLE;
						rel_q   <= '0;
					end else if (gate_lvl) begin
						rel_q <= wrap ? rel_sum - CAR_MOD : rel_sum;
					end else begin
						rel_q <= '0;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Carrier outputs
	// ----------------------------------------------------------------
	// Start phase as accumulator offset; zero is the waveform origin
	always_comb begin
		ph_off = '0;
		if (counted) begin
			if (phase_q < 0) begin
				ph_off = 38'(20'(phase_q + 20'(PH_FULL_MDEG))) * PH_SCALE;
			end else if (phase_q != 20'(PH_FULL_MDEG)) begin
				ph_off = 38'(phase_q) * PH_SCALE;
			end
		end
		abs_ph = rel_q + ph_off;
		// A sum past 38 bits wraps below rel_q; subtracting still gives the right phase
		if (abs_ph >= CAR_MOD || abs_ph < rel_q) begin
			abs_ph = abs_ph - CAR_MOD;
		end
	end

	// Registered carrier enable and phase
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			CARRIER_ON    <= 1'b0;
			CARRIER_PHASE <= '0;
			BURST_ACTIVE  <= 1'b0;
		end else begin
			CARRIER_ON    <= !burst_en || (state_q == ST_RUN) ||
				(state_q == ST_GATE && gate_lvl);
			CARRIER_PHASE <= abs_ph;
			BURST_ACTIVE  <= (state_q == ST_RUN);
		end
	end

endmodule

// ===== verification/bmc_burst_ctrl_props.sv
// Port-level checker of the burst modulation controller
`timescale 1ns/1ps
module bmc_props
	import bmc_pkg::*;
(
	// Clock and reset
	input wire logic                  CLK,
	input wire logic                  RST,
	// Bus and pins
	input wire logic                  PSEL,
	input wire logic                  PENABLE,
	input wire logic                  PWRITE,
	input wire logic [7:0]            PADDR,
	input wire logic                  EXT_TRIG,
	input wire logic                  BACKPLANE_TRIG,
	// Carrier control
	input wire logic                  CARRIER_ON,
	input wire logic [37:0]           CARRIER_PHASE,
	input wire logic                  BURST_ACTIVE,
	input wire bmc_pkg::bmc_ctrl_type CTRL_OUT
);
	// Mode decode and selected gate pin
	logic burst_m, gate_m, cnt_m, pin, ctrl_wr;
	assign burst_m = CTRL_OUT.mod_mode == MOD_BURST;
	assign gate_m  = burst_m && CTRL_OUT.src_ext;
	assign cnt_m   = burst_m && !CTRL_OUT.src_ext;
	assign pin     = (CTRL_OUT.trig_src == TRG_BPL) ? BACKPLANE_TRIG : EXT_TRIG;
	assign ctrl_wr = PSEL && PENABLE && PWRITE && PADDR == A_CTRL;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	// Gate held steady long enough to pass the synchroniser
	sequence s_gate_hi; (gate_m && pin) [*5]; endsequence
	sequence s_gate_lo; (gate_m && !pin) [*5]; endsequence
	property p_gate_hi; s_gate_hi |-> CARRIER_ON; endproperty
	property p_gate_lo; s_gate_lo |-> !CARRIER_ON && CARRIER_PHASE == 38'h0; endproperty
	property p_gate_nb; gate_m [*3] |-> !BURST_ACTIVE; endproperty
	property p_off; !burst_m [*3] |-> CARRIER_ON && !BURST_ACTIVE; endproperty
	property p_idle; (cnt_m && !BURST_ACTIVE) [*3] |-> !CARRIER_ON; endproperty
	property p_start; $rose(BURST_ACTIVE) |-> ##[0:1] CARRIER_ON; endproperty
	property p_move; CARRIER_ON && $past(CARRIER_ON) |-> !$stable(CARRIER_PHASE); endproperty
	property p_range; CARRIER_PHASE < CAR_MOD; endproperty
	property p_ctrl; !$stable(CTRL_OUT) |-> $past(ctrl_wr); endproperty

	a_gate_hi: assert property (p_gate_hi)
		else $error("gate high but carrier off");
	a_gate_lo: assert property (p_gate_lo)
		else $error("gate low but carrier on");
	a_gate_nb: assert property (p_gate_nb)
		else $error("counted burst in gated mode");
	a_off: assert property (p_off)
		else $error("carrier not continuous outside burst mode");
	a_idle: assert property (p_idle)
		else $error("carrier on between bursts");
	a_start: assert property (p_start)
		else $error("burst started without carrier");
	a_move: assert property (p_move)
		else $error("carrier phase stuck");
	a_range: assert property (p_range)
		else $error("carrier phase beyond one turn");
	a_ctrl: assert property (p_ctrl)
		else $error("mode changed without a write");
endmodule

bind bmc_burst_ctrl bmc_props i_bmc_props (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
	.EXT_TRIG, .BACKPLANE_TRIG, .CARRIER_ON, .CARRIER_PHASE, .BURST_ACTIVE, .CTRL_OUT);

// ===== verification/bmc_gate_src.sv
// Model of the external gate source on the front pin and backplane line
`timescale 1ns/1ps
module bmc_gate_src (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Bench request
	input  wire logic       gate_lvl,
	input  wire logic       use_bpl,
	input  wire logic [1:0] lag,
	// Driven lines
	output logic            ext_pin,
	output logic            bpl_pin
);
	logic [3:0] dly_q;
	logic       tgl_q;
	logic       lvl;
	// Delay line for slow answers, toggler for the unused line
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			dly_q <= 4'h0;
			tgl_q <= 1'b0;
		end else begin
			dly_q <= {dly_q[2:0], gate_lvl};
			tgl_q <= ~tgl_q;
		end
	end
	// Selected line carries a clean logic level, the other one toggles
	assign lvl     = (lag == 2'h0) ? gate_lvl : dly_q[lag];
	assign ext_pin = use_bpl ? tgl_q : lvl;
	assign bpl_pin = use_bpl ? lvl : tgl_q;
endmodule

// ===== verification/bmc_burst_ctrl_tb.sv
// Self-checking bench of the burst modulation controller
`timescale 1ns/1ps
module bmc_burst_ctrl_tb;
	import bmc_pkg::*;
	logic                  CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic                  EXT_TRIG, BACKPLANE_TRIG, CARRIER_ON, BURST_ACTIVE, IRQ;
	logic [7:0]            PADDR;
	logic [31:0]           PWDATA, PRDATA, rng, v;
	logic [37:0]           CARRIER_PHASE;
	bmc_pkg::bmc_ctrl_type CTRL_OUT;
	logic                  gate_lvl, use_bpl;
	logic [1:0]            lag;
	logic [33:0]           note;
	logic [33:0]           notes[$];
	int                    num_errors, n_tests, n, w;

	bmc_burst_ctrl i_bmc_burst_ctrl (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .EXT_TRIG(EXT_TRIG), .BACKPLANE_TRIG(BACKPLANE_TRIG),
		.CARRIER_ON(CARRIER_ON), .CARRIER_PHASE(CARRIER_PHASE), .BURST_ACTIVE(BURST_ACTIVE),
		.CTRL_OUT(CTRL_OUT), .IRQ(IRQ));
	bmc_gate_src i_bmc_gate_src (.clk(CLK), .rst(RST), .gate_lvl(gate_lvl), .use_bpl(use_bpl),
		.lag(lag), .ext_pin(EXT_TRIG), .bpl_pin(BACKPLANE_TRIG));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [31:0] cw(input logic [1:0] t, input logic e, input logic [2:0] s);
		return {23'h0, s, t, e, MOD_BURST};
	endfunction
	task automatic chk_bus(input logic [32:0] got, input logic [32:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t bus got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t pin got %b exp %b", $time, got, exp);
		end
	endtask
	// One APB transfer; the note tells the monitor what to expect
	task automatic apb(input logic wr_n, input logic [7:0] a, input logic [31:0] d,
		input logic dchk, input logic err);
		@(posedge CLK);
		PSEL    <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE  <= wr_n;
		PADDR   <= a;
		PWDATA  <= d;
		notes.push_back({dchk, err, d});
		@(posedge CLK);
		PENABLE <= 1'b1;
		@(posedge CLK);
		while (PREADY !== 1'b1) @(posedge CLK);
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b0, 1'b0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, e, 1'b1, 1'b0);
	endtask
	// Bounded wait for a carrier level, then compare
	task automatic wait_on(input logic e);
		for (int i = 0; i < 20 && CARRIER_ON !== e; i++) @(negedge CLK);
		chk_pin(CARRIER_ON, e);
	endtask
	// Clocks waited for the next burst and its length
	task automatic burst(input int lim, output int wt, output int len);
		wt = 0;
		len = 0;
		while (BURST_ACTIVE !== 1'b1 && wt < lim) begin
			@(negedge CLK);
			wt++;
		end
		while (BURST_ACTIVE === 1'b1 && len < 20000) begin
			@(negedge CLK);
			len++;
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Every completed transfer is matched against the oldest note
	always @(posedge CLK) begin
		if (PSEL && PENABLE && PREADY === 1'b1 && notes.size() > 0) begin
			note = notes.pop_front();
			chk_bus({PSLVERR, note[33] ? PRDATA : note[31:0]}, note[32:0]);
		end
	end
	// Clock and watchdog
	initial begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end
	initial begin
		#500000;
		num_errors++;
		end_sim();
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		{RST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {1'b1, 43'h0};
		{gate_lvl, use_bpl, lag, rng} = {4'h0, 32'h00007B10};
		repeat (4) @(posedge CLK);
		RST <= 1'b0;
		rd(A_COUNT, 32'(CNT_DEF));
		rd(A_PHASE, 32'(PH_DEF));
		rd(A_RATE, 32'(RATE_DEF));
		rd(A_FREQ, 32'(F_DEF));
		rd(A_CTRL, 32'h0);
		apb(1'b0, 8'h2C, 32'h0, 1'b0, 1'b1);
		apb(1'b1, A_STATUS, 32'h3, 1'b0, 1'b1);
		$display("defaults done");
		wr(A_COUNT, 32'h0);
		rd(A_COUNT, 32'h1);
		wr(A_COUNT, 32'hC351);
		rd(A_COUNT, 32'(CNT_MAX));
		wr(A_COUNT, 32'h80000005);
		rd(A_COUNT, CNT_INF_READ);
		wr(A_PHASE, PH_MIN - 32'h1);
		rd(A_PHASE, PH_MIN);
		wr(A_RATE, 32'h9);
		rd(A_RATE, RATE_MIN);
		wr(A_RATE, RATE_MAX + 32'h1);
		rd(A_RATE, RATE_MAX);
		for (int k = 0; k < 6; k++) begin
			rng = xs(rng);
			v = rng % 32'hC350 + 32'h1;
			wr(A_COUNT, v);
			rd(A_COUNT, v);
			rng = xs(rng);
			v = rng % 32'h000AFC81 - PH_MAX;
			wr(A_PHASE, v);
			rd(A_PHASE, v);
		end
		wr(A_PHASE, 32'hFFFBE150);
		for (int m = 0; m < 6; m++) begin
			wr(A_CTRL, 32'(m));
			rd(A_CTRL, 32'(m));
			wait_on(1'(m != 5));
		end
		$display("ranges and modes done");
		wr(A_IRQ_EN, 32'h1);
		wr(A_COUNT, 32'h2);
		wr(A_FREQ, 32'h11E1A300);
		rd(A_FREQ, 32'(F_STEP) * 32'h2);
		rd(A_STATUS, 32'h1);
		rd(A_ERR, ERR_CONFLICT);
		chk_pin(IRQ, 1'b1);
		wr(A_IRQ_EN, 32'h0);
		wr(A_CTRL, cw(TRG_SOFT, 1'b0, SHP_TRI));
		rd(A_FREQ, 32'(F_TRI_MAX));
		@(negedge CLK);
		chk_pin(IRQ, 1'b0);
		wr(A_CTRL, cw(TRG_SOFT, 1'b0, SHP_SINE));
		wr(A_COUNT, 32'hC350);
		wr(A_FREQ, 32'h00001388);
		rd(A_FREQ, 32'(F_LOW));
		wr(A_IRQ_CLR, 32'h1);
		rd(A_STATUS, 32'h0);
		$display("conflicts done");
		wr(A_COUNT, 32'h3);
		wr(A_FREQ, 32'h11E1A300);
		wr(A_TRIG, 32'h1);
		burst(50, w, n);
		chk_pin(n >= 198 && n <= 202, 1'b1);
		wait_on(1'b0);
		chk_pin(CARRIER_PHASE == 38'h15F90 * PH_SCALE, 1'b1);
		rd(A_STATUS, 32'h2);
		burst(6000, w, n);
		chk_pin(n == 0, 1'b1);
		wr(A_CTRL, cw(TRG_INT, 1'b0, SHP_SINE));
		burst(9000, w, n);
		burst(9000, w, v);
		chk_pin(n + w >= 3998 && n + w <= 4002, 1'b1);
		wr(A_COUNT, 32'h64);
		burst(20000, w, n);
		burst(20000, w, n);
		chk_pin(w < 8 && n > 6000, 1'b1);
		rd(A_RATE, RATE_MAX);
		$display("counted bursts done");
		wr(A_CTRL, cw(TRG_EXT, 1'b1, SHP_SINE));
		gate_lvl <= 1'b1;
		wr(A_TRIG, 32'h1);
		wait_on(1'b1);
		chk_pin(BURST_ACTIVE, 1'b0);
		gate_lvl <= 1'b0;
		wait_on(1'b0);
		{use_bpl, lag} <= 3'h6;
		wr(A_CTRL, cw(TRG_BPL, 1'b1, SHP_SINE));
		gate_lvl <= 1'b1;
		wait_on(1'b1);
		gate_lvl <= 1'b0;
		wait_on(1'b0);
		{gate_lvl, use_bpl} <= 2'h2;
		wr(A_CTRL, cw(TRG_SOFT, 1'b0, SHP_SINE));
		wait_on(1'b0);
		$display("gated mode done");
		end_sim();
	end
endmodule
